// [spg_pkg.sv]
// shared constants, register map and carrier types of the pulse generator
package spg_pkg;
    // data path and register port widths
    localparam int REG_W = 40;
    localparam int ADDR_W = 4;

    // register word addresses on the plain register port
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_FIRST_DELAY = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_SECOND_DELAY = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_PERIOD = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_WIDTH = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_MOD_FREQ = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h6;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 4'h7;
    localparam logic [ADDR_W-1:0] ADDR_ERROR = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_STATE = 4'h9;

    // control register fields
    localparam int CTRL_SECOND_EN = 0;
    localparam int CTRL_FREE_RUN = 1;

    // status and mask fields
    localparam int ST_W = 4;
    localparam int ST_CONFLICT = 0;
    localparam int ST_REJECT = 1;
    localparam int ST_RANGE = 2;
    localparam int ST_PERIOD = 3;

    // live state register fields
    localparam int STATE_PULSE = 0;
    localparam int STATE_DIV_BUSY = 1;
    localparam int STATE_CONFLICT = 2;

    // settings conflict error code, two's complement at register width
    localparam logic [REG_W-1:0] ERR_CONFLICT_CODE = REG_W'(-221);

    // timing clock
    localparam longint CLK_HZ = 200_000_000;
    localparam longint CLK_MHZ = 200;
    localparam longint NS_PER_US = 1000;
    localparam longint MS_PER_S = 1000;
    localparam longint MHZ_PER_HZ = 1000;

    // printed time limits
    localparam longint T_FIRST_DELAY_MIN_NS = 20;
    localparam longint T_SECOND_DELAY_MIN_NS = 60;
    localparam longint T_PERIOD_MIN_NS = 100;
    localparam longint T_WIDTH_MIN_NS = 20;
    localparam longint T_DELAY_MAX_MS = 1300;
    localparam longint T_PERIOD_MAX_MS = 85000;

    // reset times
    localparam longint T_RST_FIRST_DELAY_NS = 1000;
    localparam longint T_RST_SECOND_DELAY_NS = 5000;
    localparam longint T_RST_PERIOD_NS = 10000;
    localparam longint T_RST_WIDTH_NS = 1000;

    // least times round up to whole cycles
    function automatic longint ns_to_cyc_up(input longint ns);
        ns_to_cyc_up = (ns * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    endfunction : ns_to_cyc_up

    // longest times round down to whole cycles
    function automatic longint ms_to_cyc_dn(input longint ms);
        ms_to_cyc_dn = ms * (CLK_HZ / MS_PER_S);
    endfunction : ms_to_cyc_dn

    localparam logic [REG_W-1:0] FIRST_DELAY_MIN_CYC = REG_W'(ns_to_cyc_up(T_FIRST_DELAY_MIN_NS));
    localparam logic [REG_W-1:0] SECOND_DELAY_MIN_CYC = REG_W'(ns_to_cyc_up(T_SECOND_DELAY_MIN_NS));
    localparam logic [REG_W-1:0] PERIOD_MIN_CYC = REG_W'(ns_to_cyc_up(T_PERIOD_MIN_NS));
    localparam logic [REG_W-1:0] WIDTH_MIN_CYC = REG_W'(ns_to_cyc_up(T_WIDTH_MIN_NS));
    localparam longint DELAY_MAX_CYC = ms_to_cyc_dn(T_DELAY_MAX_MS);
    localparam longint PERIOD_MAX_CYC = ms_to_cyc_dn(T_PERIOD_MAX_MS);

    localparam logic [REG_W-1:0] RST_FIRST_DELAY = REG_W'(ns_to_cyc_up(T_RST_FIRST_DELAY_NS));
    localparam logic [REG_W-1:0] RST_SECOND_DELAY = REG_W'(ns_to_cyc_up(T_RST_SECOND_DELAY_NS));
    localparam logic [REG_W-1:0] RST_PERIOD = REG_W'(ns_to_cyc_up(T_RST_PERIOD_NS));
    localparam logic [REG_W-1:0] RST_WIDTH = REG_W'(ns_to_cyc_up(T_RST_WIDTH_NS));

    // frequency in millihertz: f = FREQ_NUM / period_cycles
    localparam logic [REG_W-1:0] FREQ_NUM = REG_W'(CLK_HZ * MHZ_PER_HZ);
    localparam logic [REG_W-1:0] RST_MOD_FREQ = FREQ_NUM / RST_PERIOD;

    // divider job selection
    typedef enum logic [1:0] {
        SPG_DIV_IDLE = 2'b00,
        SPG_DIV_FREQ = 2'b01,
        SPG_DIV_PERIOD = 2'b10
    } spg_div_job_t;

    // timing set handed to the pulse timer
    typedef struct packed {
        logic [REG_W-1:0] period;
        logic [REG_W-1:0] first_delay;
        logic [REG_W-1:0] second_delay;
        logic [REG_W-1:0] width;
        logic second_en;
        logic free_run;
    } spg_timing_t;
endpackage : spg_pkg

// [spg_divider.sv]
// sequential restoring divider, one quotient bit per clock
`timescale 1ns/1ps
module spg_divider #(
    parameter int W = 40
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic start,
    input wire logic [W-1:0] dividend,
    input wire logic [W-1:0] divisor,
    output logic busy,
    output logic done,
    output logic [W-1:0] quotient
);
    localparam int CW = $clog2(W + 1);
    logic [W:0] rem;
    logic [W-1:0] quo;
    logic [W-1:0] dvs;
    logic [CW-1:0] count;
    logic [W:0] trial;

    // trial subtraction of the shifted remainder
    assign trial = {rem[W-1:0], quo[W-1]} - {1'b0, dvs};

    // iterate W steps; a zero divisor yields all ones, which the caller rejects as out of range
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rem <= '0;
            quo <= '0;
            dvs <= '0;
            count <= '0;
            busy <= 1'b0;
            done <= 1'b0;
            quotient <= '0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                rem <= '0;
                quo <= dividend;
                dvs <= divisor;
                count <= CW'(W);
                busy <= 1'b1;
            end else if (busy) begin
                if (trial[W]) begin
                    rem <= {rem[W-1:0], quo[W-1]};
                    quo <= {quo[W-2:0], 1'b0};
                end else begin
                    rem <= trial;
                    quo <= {quo[W-2:0], 1'b1};
                end
                count <= count - 1'b1;
                if (count == CW'(1)) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    quotient <= trial[W] ? {quo[W-2:0], 1'b0} : {quo[W-2:0], 1'b1};
                end
            end
        end
    end
endmodule : spg_divider

// [spg_pulse_timer.sv]
// period counter and pulse window logic
`timescale 1ns/1ps
module spg_pulse_timer (
    input wire logic clk,
    input wire logic rstn,
    input wire spg_pkg::spg_timing_t cfg,
    input wire logic trigger,
    output logic pulse_out,
    output logic period_start
);
    logic [spg_pkg::REG_W-1:0] cnt;
    logic [spg_pkg::REG_W-1:0] next_cnt;
    logic running;
    logic next_running;
    logic expire;
    logic start;

    // true while count c lies in the window [d, d+w)
    function automatic logic in_window(input logic [spg_pkg::REG_W-1:0] c,
                                       input logic [spg_pkg::REG_W-1:0] d,
                                       input logic [spg_pkg::REG_W-1:0] w);
        in_window = (c >= d) && ({1'b0, c} < ({1'b0, d} + {1'b0, w}));
    endfunction : in_window

    // a shortened period still ends: compare with >= not ==
    assign expire = running && (cnt >= cfg.period - 1'b1);
    assign start = cfg.free_run ? (!running || expire) : trigger;

    // next count position of the period
    always_comb begin
        next_cnt = cnt;
        next_running = running;
        if (start) begin
            next_cnt = '0;
            next_running = 1'b1;
        end else if (expire) begin
            next_running = 1'b0;
        end else if (running) begin
            next_cnt = cnt + 1'b1;
        end
    end

    // counter state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= '0;
            running <= 1'b0;
            period_start <= 1'b0;
        end else begin
            cnt <= next_cnt;
            running <= next_running;
            period_start <= start;
        end
    end

    // pulse output; second pulse reuses the first pulse width
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pulse_out <= 1'b0;
        end else begin
            pulse_out <= next_running &&
                (in_window(next_cnt, cfg.first_delay, cfg.width) ||
                 (cfg.second_en && in_window(next_cnt, cfg.second_delay, cfg.width)));
        end
    end
endmodule : spg_pulse_timer

// [spg_top.sv]
// single or double pulse generator with register port and interrupt
//
// Overview of operation
// - first pulse starts a programmed delay, 20 ns to 1.3 s, after period start.
// - with double pulse on, the effective first delay is forced to zero.
// - turning double pulse off restores the previously programmed first delay.
// - double pulse on emits a second pulse each period, same width as first.
// - second pulse starts its own programmed delay, 60 ns to 1.3 s, after period start.
// - the double pulse control bit turns the second pulse on or off, and with it the first delay lock.
// - while double pulse is on, first delay writes are rejected, delay stays zero.
// - double pulse with width above half of period minus second delay flags -221.
// - pulses repeat with a programmed period from 100 ns to 85 s.
// - period and modulation frequency are reciprocal; writing either updates the other.
// - each pulse stays active for a programmed width from 20 ns to 1.3 s.
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module spg_top #(
    parameter longint MAX_DELAY_CYC = spg_pkg::DELAY_MAX_CYC,
    parameter longint MAX_PERIOD_CYC = spg_pkg::PERIOD_MAX_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [spg_pkg::ADDR_W-1:0] addr,
    input wire logic [spg_pkg::REG_W-1:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [spg_pkg::REG_W-1:0] rd_data,
    input wire logic trigger,
    output logic pulse_out,
    output logic irq
);
    localparam logic [spg_pkg::REG_W-1:0] DELAY_MAX = spg_pkg::REG_W'(MAX_DELAY_CYC);
    localparam logic [spg_pkg::REG_W-1:0] PERIOD_MAX = spg_pkg::REG_W'(MAX_PERIOD_CYC);

    // programmed settings
    logic second_en;
    logic free_run;
    logic [spg_pkg::REG_W-1:0] first_pulse_delay;
    logic [spg_pkg::REG_W-1:0] second_pulse_delay;
    logic [spg_pkg::REG_W-1:0] pulse_period;
    logic [spg_pkg::REG_W-1:0] pulse_width;
    logic [spg_pkg::REG_W-1:0] internal_modulation_frequency;
    logic [spg_pkg::REG_W-1:0] pending_freq;
    logic [spg_pkg::ST_W-1:0] status;
    logic [spg_pkg::ST_W-1:0] mask;
    logic [spg_pkg::ST_W-1:0] st_set;
    logic [spg_pkg::ST_W-1:0] st_clr;
    spg_pkg::spg_div_job_t div_job;

    // divider and timer links
    logic div_start;
    logic [spg_pkg::REG_W-1:0] div_divisor;
    logic div_busy;
    logic div_done;
    logic [spg_pkg::REG_W-1:0] div_quotient;
    logic period_start;
    logic pulse_int;
    spg_pkg::spg_timing_t timing;

    // decoded accesses
    logic wr_ctrl;
    logic wr_first;
    logic wr_second;
    logic wr_period;
    logic wr_width;
    logic wr_freq;
    logic wr_mask;
    logic first_ok;
    logic second_ok;
    logic period_ok;
    logic width_ok;
    logic freq_ok;
    logic result_ok;
    logic conflict;
    logic reject;
    logic range_err;

    // inclusive range check shared by all timing writes
    function automatic logic in_range(input logic [spg_pkg::REG_W-1:0] v,
                                      input logic [spg_pkg::REG_W-1:0] lo,
                                      input logic [spg_pkg::REG_W-1:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction : in_range

    // write strobe decode
    assign wr_ctrl = wr_stb && (addr == spg_pkg::ADDR_CTRL);
    assign wr_first = wr_stb && (addr == spg_pkg::ADDR_FIRST_DELAY);
    assign wr_second = wr_stb && (addr == spg_pkg::ADDR_SECOND_DELAY);
    assign wr_period = wr_stb && (addr == spg_pkg::ADDR_PERIOD);
    assign wr_width = wr_stb && (addr == spg_pkg::ADDR_WIDTH);
    assign wr_freq = wr_stb && (addr == spg_pkg::ADDR_MOD_FREQ);
    assign wr_mask = wr_stb && (addr == spg_pkg::ADDR_MASK);

    // range checks of written values
    assign first_ok = in_range(wr_data, spg_pkg::FIRST_DELAY_MIN_CYC, DELAY_MAX);
    assign second_ok = in_range(wr_data, spg_pkg::SECOND_DELAY_MIN_CYC, DELAY_MAX);
    assign period_ok = in_range(wr_data, spg_pkg::PERIOD_MIN_CYC, PERIOD_MAX);
    assign width_ok = in_range(wr_data, spg_pkg::WIDTH_MIN_CYC, DELAY_MAX);
    assign freq_ok = (wr_data != '0);
    assign result_ok = in_range(div_quotient, spg_pkg::PERIOD_MIN_CYC, PERIOD_MAX);

    // refused writes: first delay locked in double mode, coupling busy, or out of range
    assign reject = (wr_first && second_en) ||
                    ((wr_period || wr_freq) && (div_busy || div_done));
    assign range_err = (wr_first && !second_en && !first_ok) ||
                       (wr_second && !second_ok) ||
                       (wr_period && !div_busy && !period_ok) ||
                       (wr_width && !width_ok) ||
                       (wr_freq && !div_busy && !freq_ok) ||
                       (div_done && div_job == spg_pkg::SPG_DIV_PERIOD && !result_ok);

    // width > (period - second delay) / 2, rearranged to avoid a negative difference
    assign conflict = second_en &&
        (({1'b0, pulse_width, 1'b0} + {2'b00, second_pulse_delay}) > {2'b00, pulse_period});

    // control bits; the stored first delay is never touched by double mode
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            second_en <= 1'b0;
            free_run <= 1'b1;
        end else if (wr_ctrl) begin
            second_en <= wr_data[spg_pkg::CTRL_SECOND_EN];
            free_run <= wr_data[spg_pkg::CTRL_FREE_RUN];
        end
    end

    // first pulse delay; kept while locked so it returns when double mode ends
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            first_pulse_delay <= spg_pkg::RST_FIRST_DELAY;
        end else if (wr_first && !second_en && first_ok) begin
            first_pulse_delay <= wr_data;
        end
    end

    // second pulse delay and common width
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            second_pulse_delay <= spg_pkg::RST_SECOND_DELAY;
            pulse_width <= spg_pkg::RST_WIDTH;
        end else begin
            if (wr_second && second_ok) begin
                second_pulse_delay <= wr_data;
            end
            if (wr_width && width_ok) begin
                pulse_width <= wr_data;
            end
        end
    end

    // divider job launch; not in the done cycle, where the job tracker would drop the new job
    always_comb begin
        div_start = 1'b0;
        div_divisor = wr_data;
        if (!div_busy && !div_done && ((wr_period && period_ok) || (wr_freq && freq_ok))) begin
            div_start = 1'b1;
        end
    end

    // job tracking for the shared divider
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_job <= spg_pkg::SPG_DIV_IDLE;
            pending_freq <= '0;
        end else begin
            case (div_job)
                spg_pkg::SPG_DIV_IDLE: begin
                    if (div_start && wr_period) begin
                        div_job <= spg_pkg::SPG_DIV_FREQ;
                    end else if (div_start) begin
                        div_job <= spg_pkg::SPG_DIV_PERIOD;
                        pending_freq <= wr_data;
                    end
                end
                spg_pkg::SPG_DIV_FREQ: begin
                    if (div_done) begin
                        div_job <= spg_pkg::SPG_DIV_IDLE;
                    end
                end
                spg_pkg::SPG_DIV_PERIOD: begin
                    if (div_done) begin
                        div_job <= spg_pkg::SPG_DIV_IDLE;
                    end
                end
                default: begin
                    div_job <= spg_pkg::SPG_DIV_IDLE;
                end
            endcase
        end
    end

    // period and frequency pair; a frequency giving an out-of-range period leaves both alone
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pulse_period <= spg_pkg::RST_PERIOD;
            internal_modulation_frequency <= spg_pkg::RST_MOD_FREQ;
        end else begin
            if (div_start && wr_period) begin
                pulse_period <= wr_data;
            end
            if (div_done && div_job == spg_pkg::SPG_DIV_FREQ) begin
                internal_modulation_frequency <= div_quotient;
            end
            if (div_done && div_job == spg_pkg::SPG_DIV_PERIOD && result_ok) begin
                pulse_period <= div_quotient;
                internal_modulation_frequency <= pending_freq;
            end
        end
    end

    spg_divider #(
        .W(spg_pkg::REG_W)
    ) u_div (
        .clk(clk),
        .rstn(rstn),
        .start(div_start),
        .dividend(spg_pkg::FREQ_NUM),
        .divisor(div_divisor),
        .busy(div_busy),
        .done(div_done),
        .quotient(div_quotient)
    );

    // timing set seen by the counter
    always_comb begin
        timing.period = pulse_period;
        timing.first_delay = second_en ? '0 : first_pulse_delay;
        timing.second_delay = second_pulse_delay;
        timing.width = pulse_width;
        timing.second_en = second_en;
        timing.free_run = free_run;
    end

    spg_pulse_timer u_timer (
        .clk(clk),
        .rstn(rstn),
        .cfg(timing),
        .trigger(trigger),
        .pulse_out(pulse_int),
        .period_start(period_start)
    );

    // event sources of the sticky status bits
    always_comb begin
        st_set = '0;
        st_set[spg_pkg::ST_CONFLICT] = conflict;
        st_set[spg_pkg::ST_REJECT] = reject;
        st_set[spg_pkg::ST_RANGE] = range_err;
        st_set[spg_pkg::ST_PERIOD] = period_start;
        st_clr = (rd_stb && addr == spg_pkg::ADDR_STATUS) ? '1 : '0;
    end

    // status clears on read, but an event in the same cycle wins
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            status <= '0;
        end else begin
            status <= (status & ~st_clr) | st_set;
        end
    end

    // interrupt mask
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mask <= '0;
        end else if (wr_mask) begin
            mask <= wr_data[spg_pkg::ST_W-1:0];
        end
    end

    // level interrupt; one cycle behind the status bit it reflects
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask);
        end
    end

    // pulse output retimed at the top for a clean flop-driven pin
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pulse_out <= 1'b0;
        end else begin
            pulse_out <= pulse_int;
        end
    end

    // read data valid the cycle after the strobe; unmapped reads return zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_data <= '0;
        end else if (rd_stb) begin
            case (addr)
                spg_pkg::ADDR_CTRL: begin
                    rd_data <= '0;
                    rd_data[spg_pkg::CTRL_SECOND_EN] <= second_en;
                    rd_data[spg_pkg::CTRL_FREE_RUN] <= free_run;
                end
                spg_pkg::ADDR_FIRST_DELAY: rd_data <= timing.first_delay;
                spg_pkg::ADDR_SECOND_DELAY: rd_data <= second_pulse_delay;
                spg_pkg::ADDR_PERIOD: rd_data <= pulse_period;
                spg_pkg::ADDR_WIDTH: rd_data <= pulse_width;
                spg_pkg::ADDR_MOD_FREQ: rd_data <= internal_modulation_frequency;
                spg_pkg::ADDR_STATUS: rd_data <= {{(spg_pkg::REG_W-spg_pkg::ST_W){1'b0}}, status};
                spg_pkg::ADDR_MASK: rd_data <= {{(spg_pkg::REG_W-spg_pkg::ST_W){1'b0}}, mask};
                spg_pkg::ADDR_ERROR: rd_data <= conflict ? spg_pkg::ERR_CONFLICT_CODE : '0;
                spg_pkg::ADDR_STATE: begin
                    rd_data <= '0;
                    rd_data[spg_pkg::STATE_PULSE] <= pulse_out;
                    rd_data[spg_pkg::STATE_DIV_BUSY] <= div_busy;
                    rd_data[spg_pkg::STATE_CONFLICT] <= conflict;
                end
                default: rd_data <= '0;
            endcase
        end else begin
            rd_data <= '0;
        end
    end
endmodule : spg_top

// [spg_top_sva.sv]
// port checker of the pulse generator and its bind
`timescale 1ns/1ps
module spg_top_sva #(parameter longint MAX_DELAY_CYC = 1000, MAX_PERIOD_CYC = 5000) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] addr,
    input wire logic [39:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [39:0] rd_data,
    input wire logic trigger,
    input wire logic pulse_out,
    input wire logic irq
);
    logic sec_en;
    logic [3:0] msk;
    logic [39:0] fd, sd, wd, hi_cnt;
    logic [15:0] since_trg;
    // shadow of accepted settings; refused values leave it unchanged
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {fd, sd, wd} <= {40'hC8, 40'h3E8, 40'hC8};
        end else if (wr_stb && wr_data >= 40'h4 && wr_data <= 40'(MAX_DELAY_CYC)) begin
            if (addr == 4'h1 && !sec_en) fd <= wr_data;
            if (addr == 4'h2 && wr_data >= 40'hC) sd <= wr_data;
            if (addr == 4'h4) wd <= wr_data;
        end
    end
    // control and mask take any value
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) {sec_en, msk} <= '0;
        else if (wr_stb && addr == 4'h0) sec_en <= wr_data[0];
        else if (wr_stb && addr == 4'h7) msk <= wr_data[3:0];
    end
    // cycles since the last trigger, parked at the top; length of the current high run
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) {since_trg, hi_cnt} <= {16'hFFFF, 40'h0};
        else begin
            since_trg <= trigger ? 16'h1 : since_trg + {15'h0, since_trg != 16'hFFFF};
            hi_cnt <= pulse_out ? hi_cnt + 40'h1 : 40'h0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_rd(logic [3:0] a); rd_stb && addr == a; endsequence
    sequence s_rise; $rose(pulse_out) && since_trg != 16'hFFFF; endsequence
    a_read_one_cycle: assert property (!$past(rd_stb) |-> rd_data == 40'h0)
        else $error("read data outside its cycle");
    a_error_code: assert property (s_rd(4'h8) |=> rd_data inside {40'h0, 40'hFFFFFFFF23})
        else $error("error register holds a wrong code");
    a_delay_zero: assert property (s_rd(4'h1) and sec_en |=> rd_data == 40'h0)
        else $error("first delay not zero in double mode");
    a_delay_restore: assert property (s_rd(4'h1) and !sec_en |=> rd_data == fd)
        else $error("first delay not restored");
    a_edge_place: assert property (s_rise |-> since_trg == (sec_en ? 40'h2 : fd + 40'h2)
        || (sec_en && since_trg == sd + 40'h2)) else $error("pulse edge misplaced");
    a_pulse_width: assert property ($fell(pulse_out) |-> hi_cnt == wd)
        else $error("pulse width wrong");
    a_mask_read: assert property (s_rd(4'h7) |=> rd_data == {36'h0, msk})
        else $error("mask readback wrong");
    a_irq_masked: assert property (msk == 4'h0 && $past(msk) == 4'h0 |-> !irq)
        else $error("interrupt while fully masked");
endmodule : spg_top_sva
bind spg_top spg_top_sva #(.MAX_DELAY_CYC(MAX_DELAY_CYC), .MAX_PERIOD_CYC(MAX_PERIOD_CYC))
    u_spg_top_sva (.clk(clk), .rstn(rstn), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data(rd_data), .trigger(trigger), .pulse_out(pulse_out), .irq(irq));

// [spg_modulator_model.sv]
// trigger source and modulator load that times every pulse
`timescale 1ns/1ps
module spg_modulator_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic fire,
    input wire logic pulse_out,
    output logic trigger,
    output logic w_vld,
    output logic [39:0] width,
    output logic g_vld,
    output logic [39:0] gap
);
    logic seen, prev, rise;
    logic [39:0] run, since;
    assign rise = pulse_out && !prev;
    // widths reported after the fall; gaps only once a first rise gave a reference
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) {trigger, w_vld, g_vld, seen, prev, run, since, width, gap} <= '0;
        else begin
            trigger <= fire;
            prev <= pulse_out;
            run <= pulse_out ? run + 40'h1 : 40'h0;
            width <= run;
            w_vld <= prev && !pulse_out;
            since <= rise ? 40'h1 : since + 40'h1;
            gap <= since;
            g_vld <= rise && seen;
            seen <= seen || rise;
        end
    end
endmodule : spg_modulator_model

// [spg_top_bench.sv]
// self-checking bench of the pulse generator
`timescale 1ns/1ps
module spg_top_bench;
    logic clk, rstn, wr_stb, rd_stb, fire, trigger, pulse_out, irq, meas_w, meas_g;
    logic rd_seen = 1'b0;
    logic [3:0] addr;
    logic [39:0] wr_data, rd_data, wv, gv, per, d1;
    logic [39:0] rd_q[$], w_q[$], g_q[$];
    logic [39:0] rst_v[6] = '{40'h2, 40'hC8, 40'h3E8, 40'h7D0, 40'hC8, 40'h5F5E100};
    int n_mismatch = 0, tests_run = 0, cyc = 0, seed = 60;
    spg_top #(.MAX_DELAY_CYC(1000), .MAX_PERIOD_CYC(5000)) u_spg_top (.clk(clk), .rstn(rstn),
        .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
        .trigger(trigger), .pulse_out(pulse_out), .irq(irq));
    spg_modulator_model u_spg_modulator_model (.clk(clk), .rstn(rstn), .fire(fire),
        .pulse_out(pulse_out), .trigger(trigger), .w_vld(meas_w), .width(wv), .g_vld(meas_g),
        .gap(gv));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    // one-cycle strobes with a free cycle after each
    task automatic wr(input logic [3:0] a, input logic [39:0] d);
        {addr, wr_data, wr_stb} <= {a, d, 1'b1};
        @(posedge clk);
        wr_stb <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [39:0] e);
        rd_q.push_back(e);
        {addr, rd_stb} <= {a, 1'b1};
        @(posedge clk);
        rd_stb <= 1'b0;
        @(posedge clk);
    endtask : rd
    task automatic shot(input int n);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (n) @(posedge clk);
    endtask : shot
    // results meet the oldest note of their kind; a note-less result is not ours
    always @(posedge clk) begin
        cyc++;
        if (rd_seen && rd_q.size() > 0) check(rd_data, rd_q.pop_front());
        if (meas_w && w_q.size() > 0) check(wv, w_q.pop_front());
        if (meas_g && g_q.size() > 0) check(gv, g_q.pop_front());
        rd_seen = rd_stb;
        if (cyc == 30000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial begin
        {rstn, wr_stb, rd_stb, fire, addr, wr_data} <= {4'h0, 44'($random(seed))};
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        g_q.push_back(40'h7D0);
        foreach (rst_v[i]) rd(4'(i), rst_v[i]);
        rd(4'h7, 40'h0);
        rd(4'hF, 40'h0);
        repeat (2400) @(posedge clk);
        wr(4'h0, 40'h0);
        repeat (2100) @(posedge clk);
        rd(4'h6, 40'h8);
        per = 40'(300 + ($random(seed) & 255));
        wr(4'h3, per);
        repeat (60) @(posedge clk);
        rd(4'h5, 40'h2E90EDD000 / per);
        wr(4'h5, 40'h17D78400);
        repeat (60) @(posedge clk);
        rd(4'h3, 40'h1F4);
        wr(4'h7, 40'h4);
        wr(4'h4, 40'h3);
        rd(4'h4, 40'hC8);
        check(irq, 1'b1);
        rd(4'h6, 40'h4);
        repeat (2) @(posedge clk);
        check(irq, 1'b0);
        wr(4'h7, 40'h0);
        d1 = 40'(4 + ($random(seed) & 63));
        wr(4'h1, d1);
        wr(4'h4, 40'h8);
        w_q.push_back(40'h8);
        shot(600);
        wr(4'h2, 40'h28);
        wr(4'h0, 40'h1);
        rd(4'h1, 40'h0);
        wr(4'h1, 40'h32);
        rd(4'h6, 40'hA);
        rd(4'h1, 40'h0);
        w_q.push_back(40'h8);
        w_q.push_back(40'h8);
        shot(600);
        wr(4'h4, 40'hE6);
        rd(4'h8, 40'h0);
        wr(4'h4, 40'hE7);
        rd(4'h8, 40'hFFFFFFFF23);
        rd(4'h9, 40'h4);
        wr(4'h0, 40'h0);
        rd(4'h1, d1);
        repeat (4) @(posedge clk);
        end_of_test();
    end
endmodule : spg_top_bench
